// >>> hw/cor_op_regs.sv
// Operational register set of the core: counter, stack, status, bank, page and port bits.
// Driven by the instruction stream on i_clk; software sees it as an AHB-Lite slave.
`timescale 1ns/100ps
`default_nettype none
module cor_op_regs
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_pin_reset_n,
   input wire cor_pkg::cor_instr_t i_instr,
   input wire cor_pkg::cor_reg_req_t i_reg,
   input wire logic [7:0] i_mem_rdata,
   input wire logic i_ext_tick,
   input wire logic i_wdt_timeout,
   input wire cor_pkg::cor_ahb_in_t i_ahb,
   output cor_pkg::cor_ahb_out_t o_ahb,
   output cor_pkg::cor_mem_req_t o_mem,
   output logic [7:0] o_reg_rdata,
   output logic [cor_pkg::PC_W-1:0] o_pc,
   output logic o_io_page,
   output logic [3:0] o_port5_data,
   output logic o_port6_data,
   output logic [cor_pkg::DEPTH_W-1:0] o_stack_depth
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] status_view(input logic [7:0] s);
      return s & cor_pkg::ST_RMASK;
   endfunction

   function automatic logic [cor_pkg::PC_W-1:0] far_target(
      input logic [7:0] page,
      input logic [cor_pkg::LOW_W-1:0] low
   );
      return {page[cor_pkg::CP_LSB +: cor_pkg::PG_W], low};
   endfunction

   function automatic logic [7:0] masked_write(
      input logic [7:0] old,
      input logic [7:0] wdata,
      input logic [7:0] mask
   );
      return (old & ~mask) | (wdata & mask);
   endfunction

   function automatic logic [7:0] file_read(
      input cor_pkg::cor_state_t s,
      input logic [cor_pkg::FA_W-1:0] a,
      input logic [7:0] mem
   );
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         cor_pkg::FA_INDIRECT: v = mem;
         cor_pkg::FA_TIME: v = s.time_cnt;
         cor_pkg::FA_PC: v = s.pc[7:0];
         cor_pkg::FA_STATUS: v = status_view(s.status);
         cor_pkg::FA_BANK: v = s.bank;
         cor_pkg::FA_PAGE: v = s.page;
         cor_pkg::FA_PORT6: v = 8'(s.port6);
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic logic [31:0] ahb_read(
      input cor_pkg::cor_state_t s,
      input logic [7:0] a
   );
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         cor_pkg::OFS_TIME: v = 32'(s.time_cnt);
         cor_pkg::OFS_PC: v = 32'(s.pc);
         cor_pkg::OFS_STATUS: v = 32'(status_view(s.status));
         cor_pkg::OFS_BANK: v = 32'(s.bank);
         cor_pkg::OFS_PAGE: v = 32'(s.page);
         cor_pkg::OFS_PORT6: v = 32'(s.port6);
         cor_pkg::OFS_CTRL: v = 32'(s.ext_src);
         cor_pkg::OFS_STACK: v = 32'(s.depth);
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // ****************************************
   // State
   // ****************************************
   cor_pkg::cor_state_t r;
   cor_pkg::cor_state_t n;
   logic [cor_pkg::PC_W-1:0] pc_inc;
   logic [7:0] sum_low;
   logic [cor_pkg::SP_W-1:0] pop_idx;
   logic time_written;
   logic keep_p;
   logic keep_t;
   logic ahb_take;
   logic ahb_wr;
   logic core_wr;
   logic core_rd;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb
   begin
      n = r;
      pc_inc = r.pc + cor_pkg::PC_STEP;
      sum_low = pc_inc[7:0] + i_instr.accumulator;
      pop_idx = r.sp - cor_pkg::SP_STEP;
      time_written = 1'b0;
      keep_p = 1'b0;
      keep_t = 1'b0;
      ahb_take = i_ahb.hsel & i_ahb.htrans[cor_pkg::HTRANS_ACT_BIT] & i_ahb.hready;
      ahb_wr = r.dp_valid & r.dp_write & r.dp_hit;
      core_wr = i_reg.wr;
      core_rd = i_reg.rd;

      // Bus address phase
      n.dp_valid = ahb_take;
      n.dp_write = i_ahb.hwrite;
      n.dp_hit = (i_ahb.haddr[31:8] == 24'h00_0000);
      n.dp_addr = i_ahb.haddr[7:0];

      // Bus data phase write; core writes below take priority
      if (ahb_wr)
      begin
         unique case (r.dp_addr)
            cor_pkg::OFS_TIME:
            begin
               n.time_cnt = i_ahb.hwdata[7:0];
               time_written = 1'b1;
            end
            cor_pkg::OFS_STATUS:
               n.status = masked_write(r.status, i_ahb.hwdata[7:0], cor_pkg::ST_WMASK);
            cor_pkg::OFS_BANK: n.bank = i_ahb.hwdata[7:0];
            cor_pkg::OFS_PAGE: n.page = i_ahb.hwdata[7:0];
            cor_pkg::OFS_PORT6: n.port6 = i_ahb.hwdata[0];
            cor_pkg::OFS_CTRL: n.ext_src = i_ahb.hwdata[0];
            default:
            begin
            end
         endcase
      end

      // Core register write; indirect writes go out to data memory
      if (core_wr)
      begin
         unique case (i_reg.addr)
            cor_pkg::FA_TIME:
            begin
               n.time_cnt = i_reg.wdata;
               time_written = 1'b1;
            end
            cor_pkg::FA_STATUS:
               n.status = masked_write(n.status, i_reg.wdata, cor_pkg::ST_WMASK);
            cor_pkg::FA_BANK: n.bank = i_reg.wdata;
            cor_pkg::FA_PAGE: n.page = i_reg.wdata;
            cor_pkg::FA_PORT6: n.port6 = i_reg.wdata[0];
            default:
            begin
            end
         endcase
      end

      // Core register read, answered one cycle later
      if (core_rd)
      begin
         n.core_rdata = file_read(r, i_reg.addr, i_mem_rdata);
      end

      // Time counter advance from the chosen source
      if (!time_written && (r.ext_src ? i_ext_tick : i_instr.valid))
      begin
         n.time_cnt = r.time_cnt + cor_pkg::TIME_STEP;
      end

      // Watchdog timeout clears the timeout bit; a same-cycle set below wins
      if (i_wdt_timeout)
      begin
         n.status[cor_pkg::ST_T] = 1'b0;
      end

      // Instruction execution
      if (i_instr.valid)
      begin
         n.pc = pc_inc;
         unique case (i_instr.op)
            cor_pkg::STEP_OP:
            begin
            end
            cor_pkg::JUMP_OP:
               n.pc = far_target(r.page, i_instr.operand);
            cor_pkg::CALL_OP:
            begin
               n.stack[r.sp] = pc_inc;
               n.sp = r.sp + cor_pkg::SP_STEP;
               if (r.depth != cor_pkg::DEPTH_FULL)
               begin
                  n.depth = r.depth + cor_pkg::DEPTH_ONE;
               end
               n.pc = far_target(r.page, i_instr.operand);
            end
            cor_pkg::SUBROUTINE_EXIT_OP,
            cor_pkg::EXIT_WITH_LITERAL_OP,
            cor_pkg::INTERRUPT_EXIT_OP:
            begin
               n.pc = r.stack[pop_idx];
               n.sp = pop_idx;
               if (r.depth != '0)
               begin
                  n.depth = r.depth - cor_pkg::DEPTH_ONE;
               end
            end
            cor_pkg::MOVE_TO_PC_OP:
               n.pc = far_target(r.page, {2'b00, i_instr.accumulator});
            cor_pkg::ADD_TO_PC_OP:
               n.pc = far_target(r.page, {2'b00, sum_low});
            cor_pkg::TABLE_OFFSET_OP:
               n.pc = far_target(r.page, {pc_inc[cor_pkg::PC_HOLD_LSB +: 2], sum_low});
            cor_pkg::POWER_DOWN_OP:
            begin
               n.status[cor_pkg::ST_P] = 1'b0;
               n.status[cor_pkg::ST_T] = 1'b1;
            end
            cor_pkg::WATCHDOG_CLEAR_OP:
            begin
               n.status[cor_pkg::ST_P] = 1'b1;
               n.status[cor_pkg::ST_T] = 1'b1;
            end
            default:
            begin
            end
         endcase
         if (i_instr.flag_we)
         begin
            n.status[2:0] = i_instr.flags;
         end
      end

      // Reset pin: everything restarts but the cause bits survive
      if (!i_pin_reset_n)
      begin
         keep_p = n.status[cor_pkg::ST_P];
         keep_t = n.status[cor_pkg::ST_T];
         n = cor_pkg::STATE_RST;
         n.status[cor_pkg::ST_P] = keep_p;
         n.status[cor_pkg::ST_T] = keep_t;
      end

      // Bus read data reflects every update of this cycle
      n.ahb_rdata = 32'h0000_0000;
      if (ahb_take && !i_ahb.hwrite && n.dp_hit)
      begin
         n.ahb_rdata = ahb_read(n, i_ahb.haddr[7:0]);
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         r <= cor_pkg::STATE_RST;
      end
      else if (i_ce)
      begin
         r <= n;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_comb
   begin
      o_mem.rd = i_ce & i_reg.rd & (i_reg.addr == cor_pkg::FA_INDIRECT);
      o_mem.wr = i_ce & i_reg.wr & (i_reg.addr == cor_pkg::FA_INDIRECT);
      o_mem.bank = r.bank[cor_pkg::BANK_LSB +: cor_pkg::BANK_W];
      o_mem.index = r.bank[cor_pkg::IDX_LSB +: cor_pkg::IDX_W];
      o_mem.wdata = i_reg.wdata;
      o_ahb.hreadyout = 1'b1;
      o_ahb.hresp = 1'b0;
      o_ahb.hrdata = r.ahb_rdata;
   end

   assign o_reg_rdata = r.core_rdata;
   assign o_pc = r.pc;
   assign o_io_page = r.status[cor_pkg::ST_PAGE];
   assign o_port5_data = r.page[cor_pkg::P5_LSB +: 4];
   assign o_port6_data = r.port6;
   assign o_stack_depth = r.depth;
endmodule
`default_nettype wire

// >>> shared/cor_pkg.sv
// Constants and carrier types of the operational register block.
// Assumes one 40 MHz core clock, a synchronous active-low reset and an AHB-Lite master.
`default_nettype none
package cor_pkg;
   // ****************************************
   // Sizes
   // ****************************************
   localparam int unsigned PC_W = 14;
   localparam int unsigned LOW_W = 10;
   localparam int unsigned PG_W = 4;
   localparam int unsigned STK_N = 8;
   localparam int unsigned SP_W = 3;
   localparam int unsigned DEPTH_W = 4;
   localparam int unsigned FA_W = 6;
   localparam int unsigned IDX_W = 6;
   localparam int unsigned BANK_W = 2;
   // ****************************************
   // Core-side register file addresses
   // ****************************************
   localparam logic [5:0] FA_INDIRECT = 6'h00;
   localparam logic [5:0] FA_TIME = 6'h01;
   localparam logic [5:0] FA_PC = 6'h02;
   localparam logic [5:0] FA_STATUS = 6'h03;
   localparam logic [5:0] FA_BANK = 6'h04;
   localparam logic [5:0] FA_PAGE = 6'h05;
   localparam logic [5:0] FA_PORT6 = 6'h06;
   // ****************************************
   // AHB-Lite byte offsets
   // ****************************************
   localparam logic [7:0] OFS_TIME = 8'h00;
   localparam logic [7:0] OFS_PC = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_BANK = 8'h0c;
   localparam logic [7:0] OFS_PAGE = 8'h10;
   localparam logic [7:0] OFS_PORT6 = 8'h14;
   localparam logic [7:0] OFS_CTRL = 8'h18;
   localparam logic [7:0] OFS_STACK = 8'h1c;
   localparam int unsigned HTRANS_ACT_BIT = 1;
   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int unsigned ST_P = 3;
   localparam int unsigned ST_T = 4;
   localparam int unsigned ST_PAGE = 6;
   localparam logic [7:0] ST_WMASK = 8'h47;
   localparam logic [7:0] ST_RMASK = 8'h5f;
   localparam int unsigned IDX_LSB = 0;
   localparam int unsigned BANK_LSB = 6;
   localparam int unsigned CP_LSB = 0;
   localparam int unsigned P5_LSB = 4;
   localparam int unsigned PC_HOLD_LSB = 8;
   localparam logic [7:0] RST_STATUS = 8'h18;
   localparam logic [PC_W-1:0] PC_STEP = 14'h0001;
   localparam logic [7:0] TIME_STEP = 8'h01;
   localparam logic [SP_W-1:0] SP_STEP = 3'h1;
   localparam logic [DEPTH_W-1:0] DEPTH_ONE = 4'h1;
   localparam logic [DEPTH_W-1:0] DEPTH_FULL = 4'h8;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      STEP_OP, JUMP_OP, CALL_OP, SUBROUTINE_EXIT_OP, EXIT_WITH_LITERAL_OP,
      INTERRUPT_EXIT_OP, MOVE_TO_PC_OP, ADD_TO_PC_OP, TABLE_OFFSET_OP,
      POWER_DOWN_OP, WATCHDOG_CLEAR_OP
   } cor_op_t;
   typedef struct packed {
      logic valid;
      cor_op_t op;
      logic [LOW_W-1:0] operand;
      logic [7:0] accumulator;
      logic flag_we;
      logic [2:0] flags;
   } cor_instr_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [FA_W-1:0] addr;
      logic [7:0] wdata;
   } cor_reg_req_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [BANK_W-1:0] bank;
      logic [IDX_W-1:0] index;
      logic [7:0] wdata;
   } cor_mem_req_t;
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } cor_ahb_in_t;
   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } cor_ahb_out_t;
   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [STK_N-1:0][PC_W-1:0] stack;
      logic [SP_W-1:0] sp;
      logic [DEPTH_W-1:0] depth;
      logic [7:0] time_cnt;
      logic [7:0] status;
      logic [7:0] bank;
      logic [7:0] page;
      logic port6;
      logic ext_src;
      logic [7:0] core_rdata;
      logic [31:0] ahb_rdata;
      logic dp_valid;
      logic dp_write;
      logic dp_hit;
      logic [7:0] dp_addr;
   } cor_state_t;
   localparam cor_state_t STATE_RST = '{status: RST_STATUS, default: '0};
endpackage
`default_nettype wire

// >>> verif/cor_op_regs_props.sv
// Port-level assertions for the operational register block.
// Sees only the top module ports; bound to every cor_op_regs instance.
`timescale 1ns/100ps
`default_nettype none
module cor_op_regs_chk
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_pin_reset_n,
   input wire cor_pkg::cor_instr_t i_instr,
   input wire cor_pkg::cor_reg_req_t i_reg,
   input wire logic [7:0] i_mem_rdata,
   input wire logic i_ext_tick,
   input wire logic i_wdt_timeout,
   input wire cor_pkg::cor_ahb_in_t i_ahb,
   input wire cor_pkg::cor_ahb_out_t o_ahb,
   input wire cor_pkg::cor_mem_req_t o_mem,
   input wire logic [7:0] o_reg_rdata,
   input wire logic [cor_pkg::PC_W-1:0] o_pc,
   input wire logic o_io_page,
   input wire logic [3:0] o_port5_data,
   input wire logic o_port6_data,
   input wire logic [cor_pkg::DEPTH_W-1:0] o_stack_depth
);
   // ********************
   // Helpers
   // ********************
   logic go;
   logic run;
   logic addr_ok;
   logic [13:0] pinc;
   assign run = i_ce && i_pin_reset_n;
   assign go = run && i_instr.valid;
   assign addr_ok = run && i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready;
   assign pinc = o_pc + 14'h0001;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // ********************
   // Assertions
   // ********************
   AST_STEP: assert property (go && i_instr.op == cor_pkg::STEP_OP |=> o_pc == $past(pinc))
      else $error("step pc wrong");
   AST_JUMP: assert property (go && i_instr.op == cor_pkg::JUMP_OP |=> o_pc[9:0] == $past(i_instr.operand))
      else $error("jump pc wrong");
   AST_CALL: assert property (go && i_instr.op == cor_pkg::CALL_OP |=>
      o_stack_depth == ($past(o_stack_depth) == 4'h8 ? 4'h8 : $past(o_stack_depth) + 4'h1))
      else $error("call depth wrong");
   AST_RET: assert property (go && i_instr.op == cor_pkg::CALL_OP ##1 !go && i_pin_reset_n ##1 go &&
      i_instr.op inside {cor_pkg::SUBROUTINE_EXIT_OP, cor_pkg::EXIT_WITH_LITERAL_OP, cor_pkg::INTERRUPT_EXIT_OP}
      |=> o_pc == $past(o_pc, 3) + 14'h0001)
      else $error("return pc wrong");
   AST_MOVE: assert property (go && i_instr.op == cor_pkg::MOVE_TO_PC_OP |=>
      o_pc[9:0] == {2'b00, $past(i_instr.accumulator)})
      else $error("move pc wrong");
   AST_ADD: assert property (go && i_instr.op == cor_pkg::ADD_TO_PC_OP |=>
      o_pc[9:0] == {2'b00, $past(pinc[7:0]) + $past(i_instr.accumulator)})
      else $error("add pc wrong");
   AST_TABLE: assert property (go && i_instr.op == cor_pkg::TABLE_OFFSET_OP |=>
      o_pc[9:0] == {$past(pinc[9:8]), $past(pinc[7:0]) + $past(i_instr.accumulator)})
      else $error("table pc wrong");
   AST_MEMRD: assert property (run && i_reg.rd && i_reg.addr == cor_pkg::FA_INDIRECT |-> o_mem.rd)
      else $error("indirect read not issued");
   AST_BANK: assert property (run && i_reg.wr && i_reg.addr == cor_pkg::FA_BANK |=>
      {o_mem.bank, o_mem.index} == $past(i_reg.wdata))
      else $error("bank select wrong");
   AST_PORT5: assert property (addr_ok && i_ahb.hwrite && i_ahb.haddr == 32'h00000010 ##1 run && !i_reg.wr
      |=> o_port5_data == $past(i_ahb.hwdata[7:4]))
      else $error("port five wrong");
   AST_ST5: assert property (addr_ok && !i_ahb.hwrite && i_ahb.haddr == 32'h00000008
      |=> (o_ahb.hrdata & 32'hffffffa0) == 32'h00000000)
      else $error("status unused bits set");
endmodule
bind cor_op_regs cor_op_regs_chk u_cor_op_regs_chk (.*);
`default_nettype wire

// >>> verif/cor_op_regs_bench.sv
// Self-checking bench for cor_op_regs: instructions, core register port and AHB-Lite.
// One 40 MHz clock; expected values come from a small model kept here.
`timescale 1ns/100ps
`default_nettype none
module cor_op_regs_bench;
   // ********************
   // Signals and model
   // ********************
   logic i_clk, i_rst_n, i_ce, i_pin_reset_n, i_ext_tick, i_wdt_timeout;
   logic [7:0] i_mem_rdata, o_reg_rdata, st, tm, acc;
   cor_pkg::cor_instr_t i_instr;
   cor_pkg::cor_reg_req_t i_reg;
   cor_pkg::cor_ahb_in_t i_ahb;
   cor_pkg::cor_ahb_out_t o_ahb;
   cor_pkg::cor_mem_req_t o_mem;
   logic [13:0] o_pc, epc, pi;
   logic o_io_page, o_port6_data, ext, pa, pr;
   logic [3:0] o_port5_data, o_stack_depth, pg;
   logic [31:0] rnd, qa[$], qr[$];
   logic [13:0] stk[$];
   int num_errors = 0, comparisons = 0, cyc = 0;
   cor_pkg::cor_op_t seq[6] = '{cor_pkg::JUMP_OP, cor_pkg::TABLE_OFFSET_OP, cor_pkg::JUMP_OP,
      cor_pkg::ADD_TO_PC_OP, cor_pkg::MOVE_TO_PC_OP, cor_pkg::STEP_OP};
   cor_op_regs u_cor_op_regs (.*);
   // ********************
   // Tasks
   // ********************
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
      comparisons++;
      if (s !== e)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report();
      if (num_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_ahb.htrans <= 2'h2;
      i_ahb.haddr <= {24'h000000, a};
      i_ahb.hwrite <= w;
      do @(posedge i_clk); while (o_ahb.hreadyout !== 1'b1);
      i_ahb.htrans <= 2'h0;
      i_ahb.hwdata <= d;
      do @(posedge i_clk); while (o_ahb.hreadyout !== 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      qa.push_back(e);
      bus(1'b0, a, 32'h00000000);
   endtask
   task automatic creg(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_reg <= '{!w, w, a, d};
      if (!w)
         qr.push_back({24'h000000, d});
      @(posedge i_clk);
      chk({o_mem.rd, o_mem.wr, o_mem.wdata}, {!w && a == 6'h00, w && a == 6'h00, d}, "mem_strobe");
      i_reg <= '0;
   endtask
   // Pulse: 0 watchdog timeout, 1 reset pin, 2 external tick
   task automatic pulse(input int k);
      @(posedge i_clk);
      {i_ext_tick, i_pin_reset_n, i_wdt_timeout} <= 3'b010 ^ (3'b001 << k);
      @(posedge i_clk);
      {i_ext_tick, i_pin_reset_n, i_wdt_timeout} <= 3'b010;
   endtask
   task automatic op(input cor_pkg::cor_op_t o, input logic [9:0] d);
      @(posedge i_clk);
      rnd = xs(rnd);
      acc = rnd[7:0];
      i_instr <= '{1'b1, o, d, acc, 1'b1, rnd[10:8]};
      if (i_ce)
      begin
         pi = epc + 14'h0001;
         tm = ext ? tm : tm + 8'h01;
         st[2:0] = rnd[10:8];
         epc = pi;
         case (o)
            cor_pkg::JUMP_OP, cor_pkg::CALL_OP: epc = {pg, d};
            cor_pkg::MOVE_TO_PC_OP: epc = {pg, 2'b00, acc};
            cor_pkg::ADD_TO_PC_OP: epc = {pg, 2'b00, pi[7:0] + acc};
            cor_pkg::TABLE_OFFSET_OP: epc = {pg, pi[9:8], pi[7:0] + acc};
            cor_pkg::SUBROUTINE_EXIT_OP, cor_pkg::EXIT_WITH_LITERAL_OP,
            cor_pkg::INTERRUPT_EXIT_OP: epc = stk.pop_back();
            cor_pkg::POWER_DOWN_OP: st[4:3] = 2'b10;
            cor_pkg::WATCHDOG_CLEAR_OP: st[4:3] = 2'b11;
            default: epc = pi;
         endcase
         if (o == cor_pkg::CALL_OP)
            stk.push_back(pi);
         if (stk.size() > 8)
            stk.delete(0);
      end
      @(posedge i_clk);
      i_instr.valid <= 1'b0;
   endtask
   // Compares read data in the cycle after each taken read
   always @(posedge i_clk)
   begin
      if (pa)
      begin
         chk(o_ahb.hrdata, qa.pop_front(), "hrdata");
         chk(o_ahb.hresp, 1'b0, "hresp");
      end
      if (pr)
         chk({24'h000000, o_reg_rdata}, qr.pop_front(), "reg_rdata");
      pa = i_ahb.hsel && i_ahb.htrans[1] && !i_ahb.hwrite;
      pr = i_reg.rd && i_ce;
      cyc++;
      if (cyc == 4000)
      begin
         num_errors++;
         final_report();
      end
   end
   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // ********************
   // Sequence
   // ********************
   initial
   begin
      rnd = 32'h0000221e;
      {i_rst_n, i_pin_reset_n, i_ce, i_ext_tick, i_wdt_timeout, pa, pr, ext} = 8'h60;
      i_instr = '0;
      i_reg = '0;
      i_ahb = '{1'b1, 32'h00000000, 2'h0, 1'b0, 3'h2, 32'h00000000, 1'b1};
      i_mem_rdata = 8'h00;
      {epc, st, tm, pg} = {14'h0000, 8'h18, 8'h00, 4'h0};
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (int i = 0; i < 9; i++)
         rd(8'(4 * i), i == 2 ? 32'h00000018 : 32'h00000000);
      bus(1'b1, cor_pkg::OFS_STATUS, 32'hffffffff);
      st = 8'h5f;
      rd(cor_pkg::OFS_STATUS, 32'h0000005f);
      chk(o_io_page, 1'b1, "io_page");
      rnd = xs(rnd);
      bus(1'b1, cor_pkg::OFS_BANK, rnd);
      rd(cor_pkg::OFS_BANK, {24'h000000, rnd[7:0]});
      chk({o_mem.bank, o_mem.index}, rnd[7:0], "mem_select");
      bus(1'b1, cor_pkg::OFS_PAGE, 32'h000000a5);
      pg = 4'h5;
      rd(cor_pkg::OFS_PAGE, 32'h000000a5);
      chk(o_port5_data, 4'ha, "port5");
      bus(1'b1, cor_pkg::OFS_PORT6, 32'hffffffff);
      rd(cor_pkg::OFS_PORT6, 32'h00000001);
      chk(o_port6_data, 1'b1, "port6");
      bus(1'b1, cor_pkg::OFS_PC, 32'h00003fff);
      rd(cor_pkg::OFS_PC, 32'h00000000);
      foreach (seq[i])
      begin
         rnd = xs(rnd);
         op(seq[i], {2'b11, rnd[7:0]});
         rd(cor_pkg::OFS_PC, {18'h00000, epc});
         rd(cor_pkg::OFS_STATUS, {24'h000000, st});
      end
      // Clock enable low: the instruction must leave no trace
      i_ce <= 1'b0;
      op(cor_pkg::JUMP_OP, 10'h000);
      i_ce <= 1'b1;
      rd(cor_pkg::OFS_PC, {18'h00000, epc});
      for (int i = 0; i < 9; i++)
      begin
         rnd = xs(rnd);
         op(cor_pkg::CALL_OP, rnd[9:0]);
      end
      rd(cor_pkg::OFS_STACK, 32'h00000008);
      for (int i = 0; i < 8; i++)
      begin
         op(cor_pkg::cor_op_t'(3 + i % 3), 10'h000);
         rd(cor_pkg::OFS_PC, {18'h00000, epc});
      end
      // Call straight followed by a return
      op(cor_pkg::CALL_OP, 10'h155);
      op(cor_pkg::SUBROUTINE_EXIT_OP, 10'h000);
      rd(cor_pkg::OFS_PC, {18'h00000, epc});
      rd(cor_pkg::OFS_STACK, 32'h00000000);
      op(cor_pkg::POWER_DOWN_OP, 10'h000);
      pulse(0);
      st[4] = 1'b0;
      rd(cor_pkg::OFS_STATUS, {24'h000000, st});
      op(cor_pkg::WATCHDOG_CLEAR_OP, 10'h000);
      rd(cor_pkg::OFS_STATUS, {24'h000000, st});
      pulse(0);
      st[4] = 1'b0;
      rd(cor_pkg::OFS_STATUS, {24'h000000, st});
      op(cor_pkg::POWER_DOWN_OP, 10'h000);
      pulse(1);
      {epc, st, tm, pg} = {14'h0000, 8'h10, 8'h00, 4'h0};
      stk.delete();
      rd(cor_pkg::OFS_STATUS, 32'h00000010);
      rd(cor_pkg::OFS_PC, 32'h00000000);
      bus(1'b1, cor_pkg::OFS_TIME, 32'h000000fe);
      tm = 8'hfe;
      repeat (3) op(cor_pkg::STEP_OP, 10'h000);
      rd(cor_pkg::OFS_TIME, {24'h000000, tm});
      bus(1'b1, cor_pkg::OFS_CTRL, 32'h00000001);
      ext = 1'b1;
      repeat (3) pulse(2);
      op(cor_pkg::STEP_OP, 10'h000);
      rd(cor_pkg::OFS_TIME, {24'h000000, tm + 8'h03});
      rnd = xs(rnd);
      i_mem_rdata <= rnd[15:8];
      creg(1'b0, cor_pkg::FA_INDIRECT, rnd[15:8]);
      creg(1'b1, cor_pkg::FA_INDIRECT, rnd[7:0]);
      creg(1'b1, cor_pkg::FA_BANK, rnd[23:16]);
      creg(1'b0, cor_pkg::FA_BANK, rnd[23:16]);
      repeat (3) @(posedge i_clk);
      final_report();
   end
endmodule
`default_nettype wire
